// ---- rtl/rnpc_regs.svh ----
// Constants, register map and timing of the reset and NMI pin controller
// How it works
// - A low reset pin while the clock runs starts an internal reset.
// - Reset pin low pulses under 10 ns never cause a reset.
// - Reset pin low pulses over 100 ns always pass the filter.
// - In bidirectional mode the pin is driven low during the reset sequence.
// - Reset indication goes low during any hardware, software or watchdog reset.
// - Reset indication stays low until end of init, then goes high.
// - A falling NMI pin edge raises the NMI trap.
// - Power down is entered only when the NMI pin is low.
// - With NMI high the power down request is refused and only raises the refusal interrupt event.
// - Bidirectional enable is locked once end of init has run.
// - Every reset clears the bidirectional enable.
// - In bidirectional mode the reset cause always reads long hardware reset.
// - In bidirectional mode port config is latched; bootstrap when bit 4 low.
// - In bidirectional mode a short pin reset lasts the full sequence.
`ifndef RNPC_REGS_SVH
`define RNPC_REGS_SVH
`define RNPC_CLK_PS 20000
`define RNPC_PASS_PS 100000
`define RNPC_FILT_CYC (`RNPC_PASS_PS / `RNPC_CLK_PS - 1)
`define RNPC_SEQ_CYC 8'h20
`define RNPC_BLANK_CYC 8'h06
`define RNPC_OFF_CTRL 8'h00
`define RNPC_OFF_STATUS 8'h04
`define RNPC_OFF_CFG 8'h08
`define RNPC_OFF_IRQ_STAT 8'h0C
`define RNPC_OFF_IRQ_CLR 8'h10
`define RNPC_OFF_IRQ_EN 8'h14
`define RNPC_CAUSE_LONG 4'h1
`define RNPC_CAUSE_SHORT 4'h2
`define RNPC_CAUSE_SW 4'h4
`define RNPC_CAUSE_WDT 4'h8
`define RNPC_EV_NMI 0
`define RNPC_EV_PDREF 1
`define RNPC_EV_RSTEND 2
`define RNPC_BOOT_BIT 4
`define RNPC_RESP_OKAY 2'h0
`define RNPC_RESP_SLVERR 2'h2
`endif

// ---- rtl/rnpc_pkg.sv ----
// Types shared by the reset and NMI pin controller
package rnpc_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_SEQ, ST_HOLD, ST_BLANK} rnpc_state_t;
  typedef logic [2:0] rnpc_ev_t;
endpackage

// ---- rtl/rnpc_filt_if.sv ----
// Synchronised reset pin and filtered low level between core and filter
`timescale 1ns/1ps
`default_nettype none
interface rnpc_filt_if;
  logic pin_sync;
  logic pin_low_filt;
  modport filt (input pin_sync, output pin_low_filt);
  modport core (output pin_sync, input pin_low_filt);
endinterface
`default_nettype wire

// ---- rtl/rnpc_sync.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rnpc_sync #(parameter int W = 1) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_r <= '1;
      o_q <= '1;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/rnpc_spike_filter.sv ----
// Spike filter on the synchronised reset pin
`timescale 1ns/1ps
`default_nettype none
`include "rnpc_regs.svh"
module rnpc_spike_filter
  import rnpc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  rnpc_filt_if.filt f
);
  logic [2:0] cnt_r;
  logic low_r;
  wire logic cnt_full = (cnt_r == 3'(`RNPC_FILT_CYC - 1));
  assign f.pin_low_filt = low_r;
  // Low counts only after enough consecutive low samples
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || f.pin_sync) begin
      cnt_r <= 3'h0;
      low_r <= 1'h0;
    end else if (cnt_full) begin
      low_r <= 1'h1;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  spike_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    f.pin_sync |=> !f.pin_low_filt) else $error("filter passed a high sample");
  long_pass_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!f.pin_sync)[*4] |=> f.pin_low_filt) else $error("long low pulse not passed");
endmodule
`default_nettype wire

// ---- rtl/rnpc_top.sv ----
// Reset pin, reset indication and NMI pin controller with AXI4-Lite registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rnpc_regs.svh"
module rnpc_top
  import rnpc_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_RESET_PIN_IN,
  output logic O_RESET_PIN_OUT,
  output logic O_RESET_PIN_OE,
  input wire logic I_NMI_PIN,
  input wire logic [15:0] I_LOW_BUS_PORT,
  input wire logic I_SW_RESET_REQ,
  input wire logic I_WDT_RESET_REQ,
  input wire logic I_END_OF_INIT,
  input wire logic I_POWER_DOWN_REQ,
  output logic O_RESET_INDICATION_OUT,
  output logic O_CORE_RESET_B,
  output logic O_NMI_TRAP,
  output logic O_POWER_DOWN,
  output logic O_BOOTSTRAP_EN,
  output logic O_IRQ,
  input wire logic [7:0] I_S_AXI_AWADDR,
  input wire logic I_S_AXI_AWVALID,
  output logic O_S_AXI_AWREADY,
  input wire logic [31:0] I_S_AXI_WDATA,
  input wire logic [3:0] I_S_AXI_WSTRB,
  input wire logic I_S_AXI_WVALID,
  output logic O_S_AXI_WREADY,
  output logic [1:0] O_S_AXI_BRESP,
  output logic O_S_AXI_BVALID,
  input wire logic I_S_AXI_BREADY,
  input wire logic [7:0] I_S_AXI_ARADDR,
  input wire logic I_S_AXI_ARVALID,
  output logic O_S_AXI_ARREADY,
  output logic [31:0] O_S_AXI_RDATA,
  output logic [1:0] O_S_AXI_RRESP,
  output logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY
);
  rnpc_filt_if fif ();
  logic nmi_s;
  logic [15:0] port_s;
  rnpc_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic bidir_en_r, bidir_act_r, end_of_init_instruction_done_r, src_hw_r, src_sw_r;
  logic [3:0] cause_r;
  logic [15:0] cfg_r;
  logic boot_r, drive_r, reset_indication_out_r, core_rst_b_r, pd_r, nmi_d_r, trap_r;
  rnpc_ev_t irq_stat_r, irq_en_r;
  logic irq_r;
  logic aw_rdy_r, w_rdy_r, aw_got_r, w_got_r, bvalid_r, ar_rdy_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic wstrb0_r;
  logic [1:0] bresp_r, rresp_r;

  // Pins cross into the clock domain first
  rnpc_sync #(.W(18)) u_sync (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_d({I_NMI_PIN, I_RESET_PIN_IN, I_LOW_BUS_PORT}),
    .o_q({nmi_s, fif.pin_sync, port_s})
  );
  rnpc_spike_filter u_filt (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .f(fif.filt)
  );

  // Reset sequencing
  wire logic hw_low = fif.pin_low_filt;
  wire logic in_run = (state_r == ST_RUN);
  wire logic start = in_run && (hw_low || I_SW_RESET_REQ || I_WDT_RESET_REQ);
  wire logic seq_end = (state_r == ST_SEQ) && (cnt_r == `RNPC_SEQ_CYC - 8'h01);
  wire logic blank_end = (cnt_r >= `RNPC_BLANK_CYC - 8'h01);
  wire logic bidir_act_nxt = start ? bidir_en_r : bidir_act_r;
  wire logic [3:0] cause_nxt = (bidir_act_r || (src_hw_r && hw_low)) ? `RNPC_CAUSE_LONG :
    src_hw_r ? `RNPC_CAUSE_SHORT : src_sw_r ? `RNPC_CAUSE_SW : `RNPC_CAUSE_WDT;
  wire logic latch_cfg = seq_end && (src_hw_r || bidir_act_r);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 8'h01;
    unique case (state_r)
      ST_RUN: begin
        cnt_nxt = 8'h00;
        if (start) state_nxt = ST_SEQ;
      end
      ST_SEQ: begin
        if (seq_end) begin
          cnt_nxt = 8'h00;
          // Own drive hides the pin, so wait out the blanking time
          state_nxt = bidir_act_r ? ST_BLANK : (hw_low ? ST_HOLD : ST_RUN);
        end
      end
      ST_HOLD: begin
        cnt_nxt = 8'h00;
        if (!hw_low) state_nxt = ST_RUN;
      end
      ST_BLANK: begin
        if (blank_end) begin
          cnt_nxt = cnt_r;
          if (!hw_low) state_nxt = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      state_r <= ST_SEQ;
      cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      bidir_act_r <= 1'h0;
      src_hw_r <= 1'h1;
      src_sw_r <= 1'h0;
    end else if (start) begin
      bidir_act_r <= bidir_act_nxt;
      src_hw_r <= hw_low;
      src_sw_r <= !hw_low && I_SW_RESET_REQ;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      cause_r <= `RNPC_CAUSE_LONG;
      cfg_r <= 16'h0000;
      boot_r <= 1'h0;
    end else begin
      if (seq_end) cause_r <= cause_nxt;
      if (latch_cfg) cfg_r <= port_s;
      if (latch_cfg) boot_r <= !port_s[`RNPC_BOOT_BIT];
    end
  end

  // Pin drive, core reset and reset indication
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      drive_r <= 1'h0;
      core_rst_b_r <= 1'h0;
      reset_indication_out_r <= 1'h0;
    end else begin
      drive_r <= (state_nxt == ST_SEQ) && bidir_act_nxt;
      core_rst_b_r <= (state_nxt == ST_RUN);
      if (state_nxt != ST_RUN) reset_indication_out_r <= 1'h0;
      else if (in_run && I_END_OF_INIT) reset_indication_out_r <= 1'h1;
    end
  end

  // Enable bit, init lock, power down and NMI edge
  wire logic wr_go = aw_got_r && w_got_r && !bvalid_r;
  wire logic wr_ctrl = wr_go && wstrb0_r && (awaddr_r == `RNPC_OFF_CTRL);
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B || start) begin
      bidir_en_r <= 1'h0;
      end_of_init_instruction_done_r <= 1'h0;
    end else begin
      if (wr_ctrl && !end_of_init_instruction_done_r) bidir_en_r <= wdata_r[0];
      if (in_run && I_END_OF_INIT) end_of_init_instruction_done_r <= 1'h1;
    end
  end

  wire logic pd_ask = in_run && I_POWER_DOWN_REQ && !pd_r;
  wire logic nmi_fall = nmi_d_r && !nmi_s;
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      pd_r <= 1'h0;
      nmi_d_r <= 1'h1;
      trap_r <= 1'h0;
    end else begin
      if (start) pd_r <= 1'h0;
      else if (pd_ask && !nmi_s) pd_r <= 1'h1;
      nmi_d_r <= nmi_s;
      trap_r <= nmi_fall;
    end
  end

  // Interrupt status; a new event wins over a clear
  wire logic wr_clr = wr_go && wstrb0_r && (awaddr_r == `RNPC_OFF_IRQ_CLR);
  wire logic wr_en = wr_go && wstrb0_r && (awaddr_r == `RNPC_OFF_IRQ_EN);
  wire rnpc_ev_t ev = {seq_end, pd_ask && nmi_s, nmi_fall};
  wire rnpc_ev_t clr_mask = wr_clr ? wdata_r[2:0] : 3'h0;
  wire rnpc_ev_t irq_nxt = (irq_stat_r & ~clr_mask) | ev;
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      irq_stat_r <= 3'h0;
      irq_en_r <= 3'h0;
      irq_r <= 1'h0;
    end else begin
      irq_stat_r <= irq_nxt;
      if (wr_en) irq_en_r <= wdata_r[2:0];
      irq_r <= |(irq_nxt & (wr_en ? wdata_r[2:0] : irq_en_r));
    end
  end

  // AXI4-Lite write channel
  wire logic aw_hs = I_S_AXI_AWVALID && aw_rdy_r;
  wire logic w_hs = I_S_AXI_WVALID && w_rdy_r;
  wire logic b_hs = bvalid_r && I_S_AXI_BREADY;
  wire logic wr_map = (awaddr_r == `RNPC_OFF_CTRL) || (awaddr_r == `RNPC_OFF_IRQ_CLR) ||
    (awaddr_r == `RNPC_OFF_IRQ_EN);
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      aw_rdy_r <= 1'h1;
      w_rdy_r <= 1'h1;
      aw_got_r <= 1'h0;
      w_got_r <= 1'h0;
    end else begin
      if (aw_hs) aw_rdy_r <= 1'h0;
      else if (b_hs) aw_rdy_r <= 1'h1;
      if (w_hs) w_rdy_r <= 1'h0;
      else if (b_hs) w_rdy_r <= 1'h1;
      aw_got_r <= aw_hs || (aw_got_r && !wr_go);
      w_got_r <= w_hs || (w_got_r && !wr_go);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'h0;
      bvalid_r <= 1'h0;
      bresp_r <= `RNPC_RESP_OKAY;
    end else begin
      if (aw_hs) awaddr_r <= I_S_AXI_AWADDR;
      if (w_hs) wdata_r <= I_S_AXI_WDATA;
      if (w_hs) wstrb0_r <= I_S_AXI_WSTRB[0];
      if (wr_go) bvalid_r <= 1'h1;
      else if (b_hs) bvalid_r <= 1'h0;
      if (wr_go) bresp_r <= wr_map ? `RNPC_RESP_OKAY : `RNPC_RESP_SLVERR;
    end
  end

  // AXI4-Lite read channel
  wire logic ar_hs = I_S_AXI_ARVALID && ar_rdy_r;
  wire logic r_hs = rvalid_r && I_S_AXI_RREADY;
  wire logic [31:0] st_word = {24'h000000, bidir_act_r, boot_r, pd_r, end_of_init_instruction_done_r, cause_r};
  wire logic rd_ctrl = (I_S_AXI_ARADDR == `RNPC_OFF_CTRL);
  wire logic rd_st = (I_S_AXI_ARADDR == `RNPC_OFF_STATUS);
  wire logic rd_cfg = (I_S_AXI_ARADDR == `RNPC_OFF_CFG);
  wire logic rd_is = (I_S_AXI_ARADDR == `RNPC_OFF_IRQ_STAT);
  wire logic rd_clr = (I_S_AXI_ARADDR == `RNPC_OFF_IRQ_CLR);
  wire logic rd_ie = (I_S_AXI_ARADDR == `RNPC_OFF_IRQ_EN);
  wire logic rd_map = rd_ctrl || rd_st || rd_cfg || rd_is || rd_clr || rd_ie;
  wire logic [31:0] rd_data = rd_ctrl ? {31'h0, bidir_en_r} :
    rd_st ? st_word :
    rd_cfg ? {16'h0000, cfg_r} :
    rd_is ? {29'h0, irq_stat_r} :
    rd_ie ? {29'h0, irq_en_r} : 32'h0000_0000;
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      ar_rdy_r <= 1'h1;
      rvalid_r <= 1'h0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RNPC_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        ar_rdy_r <= 1'h0;
        rvalid_r <= 1'h1;
        rdata_r <= rd_data;
        rresp_r <= rd_map ? `RNPC_RESP_OKAY : `RNPC_RESP_SLVERR;
      end else if (r_hs) begin
        ar_rdy_r <= 1'h1;
        rvalid_r <= 1'h0;
      end
    end
  end

  // The pin is only ever pulled low; the outside drives it open drain
  assign O_RESET_PIN_OUT = 1'h0;
  assign O_RESET_PIN_OE = drive_r;
  assign O_RESET_INDICATION_OUT = reset_indication_out_r;
  assign O_CORE_RESET_B = core_rst_b_r;
  assign O_NMI_TRAP = trap_r;
  assign O_POWER_DOWN = pd_r;
  assign O_BOOTSTRAP_EN = boot_r;
  assign O_IRQ = irq_r;
  assign O_S_AXI_AWREADY = aw_rdy_r;
  assign O_S_AXI_WREADY = w_rdy_r;
  assign O_S_AXI_BVALID = bvalid_r;
  assign O_S_AXI_BRESP = bresp_r;
  assign O_S_AXI_ARREADY = ar_rdy_r;
  assign O_S_AXI_RVALID = rvalid_r;
  assign O_S_AXI_RDATA = rdata_r;
  assign O_S_AXI_RRESP = rresp_r;

  rst_start_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    in_run && hw_low |=> !O_CORE_RESET_B && state_r == ST_SEQ) else $error("pin reset not started");
  bidir_drive_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    state_r == ST_SEQ && bidir_act_r |-> O_RESET_PIN_OE) else $error("pin not driven in sequence");
  ind_low_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !in_run |-> !O_RESET_INDICATION_OUT) else $error("indication high during reset");
  ind_release_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    in_run && !start && I_END_OF_INIT |=> O_RESET_INDICATION_OUT) else $error("indication not released");
  nmi_trap_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    $fell(nmi_s) |=> O_NMI_TRAP) else $error("missed NMI edge");
  pd_enter_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    in_run && !start && I_POWER_DOWN_REQ && !nmi_s |=> O_POWER_DOWN) else $error("power down not entered");
  pd_refuse_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_POWER_DOWN_REQ && nmi_s && !O_POWER_DOWN |=> !O_POWER_DOWN) else $error("power down with NMI high");
  en_lock_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    end_of_init_instruction_done_r && !start |=> $stable(bidir_en_r)) else $error("enable changed after init");
  en_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    start |=> !bidir_en_r) else $error("enable not cleared by reset");
  long_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    seq_end && bidir_act_r |=> cause_r == `RNPC_CAUSE_LONG) else $error("cause not long reset");
  boot_sel_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    seq_end && bidir_act_r |=> O_BOOTSTRAP_EN == !cfg_r[`RNPC_BOOT_BIT]) else $error("bootstrap wrong");
  stretch_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    start && bidir_en_r |=> O_RESET_PIN_OE[*8]) else $error("short reset not stretched");
endmodule
`default_nettype wire

// ---- dv/rnpc_far_end.sv ----
// Far-side model: open-drain reset source with pull-up, and NMI source
`timescale 1ns/1ps
`default_nettype none
module rnpc_far_end (
  input wire logic i_clk,
  input wire logic i_pull_low,
  input wire logic i_spike,
  input wire logic i_nmi_low,
  input wire logic i_dev_oe,
  input wire logic i_dev_out,
  output logic o_reset_pin,
  output logic o_nmi_pin
);
  logic spike_low = 1'h0;
  // Glitch of 5 ns that falls between two clock edges
  always @(posedge i_clk) begin
    if (i_spike) begin
      #5 spike_low = 1'h1;
      #5 spike_low = 1'h0;
    end
  end
  // Open drain only: either party pulls low, the pull-up gives high otherwise
  assign o_reset_pin = !(i_pull_low || spike_low || (i_dev_oe && !i_dev_out));
  // Pulled high while the source is idle
  assign o_nmi_pin = !i_nmi_low;
endmodule
`default_nettype wire

// ---- dv/rnpc_test.sv ----
// Self-checking testbench of the reset and NMI pin controller
`timescale 1ns/1ps
`default_nettype none
`include "rnpc_regs.svh"
module rnpc_test
  import rnpc_pkg::*;
;
  logic clk = 1'h0, rst_b = 1'h0, pull = 1'h0, spike = 1'h0, nmi_low = 1'h0;
  logic sw = 1'h0, wdt = 1'h0, eoi = 1'h0, pd = 1'h0;
  logic [15:0] port = 16'hFFFF;
  wire rst_pin, nmi_pin;
  logic pin_out, pin_oe, ind, core_b, trap, pdn, boot, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [3:0] causes [4] = '{`RNPC_CAUSE_SW, `RNPC_CAUSE_WDT, `RNPC_CAUSE_SHORT, `RNPC_CAUSE_LONG};
  int bad_count = 0;
  int checked = 0;

  always #10 clk = ~clk;

  rnpc_far_end rnpc_far_end_i (.i_clk(clk), .i_pull_low(pull), .i_spike(spike), .i_nmi_low(nmi_low),
    .i_dev_oe(pin_oe), .i_dev_out(pin_out), .o_reset_pin(rst_pin), .o_nmi_pin(nmi_pin));

  rnpc_top rnpc_top_i (.I_CLK(clk), .I_RST_B(rst_b), .I_RESET_PIN_IN(rst_pin), .O_RESET_PIN_OUT(pin_out),
    .O_RESET_PIN_OE(pin_oe), .I_NMI_PIN(nmi_pin), .I_LOW_BUS_PORT(port), .I_SW_RESET_REQ(sw),
    .I_WDT_RESET_REQ(wdt), .I_END_OF_INIT(eoi), .I_POWER_DOWN_REQ(pd), .O_RESET_INDICATION_OUT(ind),
    .O_CORE_RESET_B(core_b), .O_NMI_TRAP(trap), .O_POWER_DOWN(pdn), .O_BOOTSTRAP_EN(boot), .O_IRQ(irq),
    .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awvalid), .O_S_AXI_AWREADY(awready),
    .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(wstrb), .I_S_AXI_WVALID(wvalid), .O_S_AXI_WREADY(wready),
    .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid), .I_S_AXI_BREADY(bready),
    .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arvalid), .O_S_AXI_ARREADY(arready),
    .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid), .I_S_AXI_RREADY(rready));

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'h0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done && n < 100) begin
      @(posedge clk);
      n++;
      if (awvalid && awready === 1'h1) awvalid <= 1'h0;
      if (wvalid && wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        r = bresp;
        bready <= 1'h0;
        done = 1'h1;
      end
    end
    if (!done) cmp("write handshake", 32'h1, 32'h0);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'h0;
    d = 32'h0;
    r = 2'h3;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done && n < 100) begin
      @(posedge clk);
      n++;
      if (arvalid && arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        done = 1'h1;
      end
    end
    if (!done) cmp("read handshake", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    cmp("write response", 32'(`RNPC_RESP_OKAY), 32'(r));
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    cmp("read response", 32'(`RNPC_RESP_OKAY), 32'(r));
    cmp(name, e, d & m);
  endtask

  // One-cycle request: 0 software, 1 watchdog, 2 end of init, 3 power down
  task automatic strobe(input int k);
    @(posedge clk);
    sw <= (k == 0);
    wdt <= (k == 1);
    eoi <= (k == 2);
    pd <= (k == 3);
    @(posedge clk);
    {sw, wdt, eoi, pd} <= 4'h0;
  endtask

  task automatic hw_pin(input int len, input logic [15:0] pv);
    @(posedge clk);
    pull <= 1'h1;
    port <= pv;
    repeat (len) @(posedge clk);
    pull <= 1'h0;
  endtask

  task automatic wait_core(input logic lvl);
    int n;
    n = 0;
    while (core_b !== lvl && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp("core reset level", 32'(lvl), 32'(core_b));
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    wait_core(1'h1);
    cmp("indication before init", 32'h0, 32'(ind));
    // Power-on sequence ends with the pin high, so it reads as a short pin reset
    rd_chk("power-on cause", `RNPC_OFF_STATUS, 32'hF, 32'(`RNPC_CAUSE_SHORT));
    rd_chk("enable after reset", `RNPC_OFF_CTRL, 32'h1, 32'h0);
    wr(`RNPC_OFF_CTRL, 32'h1);
    rd_chk("enable before init", `RNPC_OFF_CTRL, 32'h1, 32'h1);
    strobe(2);
    settle(2);
    cmp("indication after init", 32'h1, 32'(ind));
    wr(`RNPC_OFF_CTRL, 32'h0);
    rd_chk("enable locked", `RNPC_OFF_CTRL, 32'h1, 32'h1);
    @(posedge clk);
    spike <= 1'h1;
    @(posedge clk);
    spike <= 1'h0;
    hw_pin(2, 16'hFFFF);
    settle(15);
    cmp("spike ignored", 32'h3, 32'({core_b, ind}));
    hw_pin(8, 16'hA5E5);
    wait_core(1'h0);
    cmp("device pulls pin", 32'h8, 32'({pin_oe, ind, rst_pin, pin_out}));
    settle(20);
    cmp("short pulse stretched", 32'h4, 32'({pin_oe, core_b, rst_pin}));
    wait_core(1'h1);
    cmp("pin released", 32'h0, 32'(pin_oe));
    rd_chk("bidir cause", `RNPC_OFF_STATUS, 32'h8F, 32'h81);
    rd_chk("latched port", `RNPC_OFF_CFG, 32'hFFFF, 32'hA5E5);
    cmp("bootstrap select", 32'h1, 32'(boot));
    rd_chk("enable cleared", `RNPC_OFF_CTRL, 32'h1, 32'h0);
    cmp("indication held", 32'h0, 32'(ind));
    wr(`RNPC_OFF_CTRL, 32'h1);
    strobe(1);
    wait_core(1'h0);
    cmp("watchdog drives pin", 32'h1, 32'(pin_oe));
    wait_core(1'h1);
    rd_chk("bidir watchdog cause", `RNPC_OFF_STATUS, 32'h8F, 32'h81);
    cmp("bidir watchdog bootstrap", 32'h1, 32'(boot));
    for (int k = 0; k < 4; k++) begin
      if (k < 2) strobe(k);
      else hw_pin((k == 2) ? 8 : 50, 16'h5A5A);
      wait_core(1'h0);
      cmp("reset without bidir", 32'h0, 32'({pin_oe, ind}));
      wait_core(1'h1);
      rd_chk("reset cause", `RNPC_OFF_STATUS, 32'hF, 32'(causes[k]));
      strobe(2);
      settle(2);
      cmp("indication after init", 32'h1, 32'(ind));
    end
    cmp("bootstrap off", 32'h0, 32'(boot));
    rd_chk("irq status after resets", `RNPC_OFF_IRQ_STAT, 32'h7, 32'h4);
    wr(`RNPC_OFF_IRQ_EN, 32'h0);
    wr(`RNPC_OFF_IRQ_CLR, 32'h7);
    @(posedge clk);
    nmi_low <= 1'h1;
    n = 0;
    while (trap !== 1'h1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp("nmi trap", 32'h1, 32'(trap));
    settle(1);
    cmp("trap single cycle", 32'h0, 32'({trap, irq}));
    wr(`RNPC_OFF_IRQ_EN, 32'h7);
    settle(1);
    cmp("irq enabled", 32'h1, 32'(irq));
    wstrb <= 4'hE;
    wr(`RNPC_OFF_IRQ_EN, 32'h0);
    wstrb <= 4'hF;
    rd_chk("strobe-less write", `RNPC_OFF_IRQ_EN, 32'h7, 32'h7);
    rd_chk("clear reads zero", `RNPC_OFF_IRQ_CLR, 32'hFFFF_FFFF, 32'h0);
    wr(`RNPC_OFF_IRQ_CLR, 32'h1);
    rd_chk("irq cleared", `RNPC_OFF_IRQ_STAT, 32'h7, 32'h0);
    cmp("irq low", 32'h0, 32'(irq));
    @(posedge clk);
    nmi_low <= 1'h0;
    settle(5);
    strobe(3);
    settle(2);
    cmp("power down refused", 32'h1, 32'({pdn, ind}));
    cmp("refusal irq", 32'h1, 32'(irq));
    rd_chk("refusal event", `RNPC_OFF_IRQ_STAT, 32'h7, 32'h2);
    @(posedge clk);
    nmi_low <= 1'h1;
    settle(5);
    strobe(3);
    settle(2);
    cmp("power down entered", 32'h1, 32'(pdn));
    rd_chk("power down status", `RNPC_OFF_STATUS, 32'h20, 32'h20);
    axi_rd(8'h40, d, r);
    cmp("unmapped read", 32'(`RNPC_RESP_SLVERR), 32'(r));
    cmp("unmapped data", 32'h0, d);
    axi_wr(8'h44, 32'h1, r);
    cmp("unmapped write", 32'(`RNPC_RESP_SLVERR), 32'(r));
    give_verdict();
  end

  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
